// *** vel_ramp_defines.vh ***
// Register offsets, field positions, mode and profile codes and timing constants
// for the velocity-mode ramp controller. Definitions only.
`ifndef VEL_RAMP_DEFINES_VH
`define VEL_RAMP_DEFINES_VH

// Register word offsets on the plain register port
`define REG_MODE        6'h00
`define REG_CTRL        6'h01
`define REG_STATUS      6'h02
`define REG_TARGET_VL   6'h03
`define REG_TARGET_PV   6'h04
`define REG_VMIN        6'h05
`define REG_VMAX        6'h06
`define REG_ACC_DV      6'h07
`define REG_ACC_DT      6'h08
`define REG_DEC_DV      6'h09
`define REG_DEC_DT      6'h0A
`define REG_QS_DV       6'h0B
`define REG_QS_DT       6'h0C
`define REG_MAX_PROF_V  6'h0D
`define REG_MAX_MOT_V   6'h0E
`define REG_PROF_TYPE   6'h0F
`define REG_POLARITY    6'h10
`define REG_DIM_MUL     6'h11
`define REG_DIM_DIV     6'h12
`define REG_WIN         6'h13
`define REG_WIN_TIME    6'h14
`define REG_THR         6'h15
`define REG_THR_TIME    6'h16
`define REG_SLIP_MAX    6'h17
`define REG_SLIP_TIME   6'h18
`define REG_DEMAND      6'h19
`define REG_ACTUAL      6'h1A
`define REG_ACTUAL_RPM  6'h1B
`define REG_POS_SAMPLE  6'h1C
`define REG_POS_BASE    6'h1D
`define REG_PV_ACC      6'h1E
`define REG_PV_DEC      6'h1F
`define REG_QS_DEC_POS  6'h20
`define REG_JERK0       6'h21

// Mode codes written by the master
`define MODE_VL         8'h02
`define MODE_PV         8'h03
// Motion profile type codes
`define PROF_TRAP       8'h00
`define PROF_JERK       8'h03
// Control bits
`define CTRL_HALT       8
`define CTRL_QSTOP      2
// Status bits
`define STS_REACHED     10
`define STS_LIMIT       11
`define STS_ZERO        12
`define STS_SLIP        13
`define STS_JERK_ON     14
// Polarity bit that reverses the profile velocity target speed
`define POL_VEL_BIT     6

// Timing: control tick 1 ms, clock 25 ns
`define TICK_MS         1
`define CLK_NS          25
`define TICK_CYCLES     ((`TICK_MS * 1000000) / `CLK_NS)

`endif

// *** vel_ramp_ctrl.v ***
// Velocity-mode ramp generator with clamp, halt, quick stop and status.
// Assumes a register master on the same clock and a sensed speed,
// position, slip error and quick-stop state coming from outside pins.
// How it works
// - Sample position each 1 ms, hold offset base
// - Profile type 0 no jerk, 3 jerk limits
// - Profile type resets to 0
// - Speed limited to smaller of two maxima
// - Halt bit stops, ramps up, brakes
// - Status bit 11 while a limit acts, in basic velocity mode only
// - Dimension factor converts speed to rpm
// - Acceleration is speed change over seconds
// - Deceleration same layout, positive change
// - Clamp target between min and max
// - Quick-stop ramp from its own object
// - Ramp tracks target, demand and actual readable
// - Basic velocity never uses jerk ramps
// - Profile velocity halt stops and restarts
// - Bits 10 and 8 encode four states
// - Bit 12 cleared above threshold for time
// - Bit 13 set on long slippage error
// - Quick-stop active uses quick-stop deceleration
// - Polarity bit 6 reverses profile velocity target sign
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "vel_ramp_defines.vh"

module vel_ramp_ctrl #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter W = 32
) (
    input wire clk_sys_i,            // System clock 40 MHz
    input wire nrst_i,               // Asynchronous reset, active low
    input wire [5:0] addr_i,         // Register word address
    input wire [31:0] wdata_i,       // Write data
    input wire wr_i,                 // Write strobe
    input wire rd_i,                 // Read strobe
    input wire [W-1:0] speed_act_i,  // Measured speed, signed
    input wire [31:0] pos_act_i,     // Axis position
    input wire target_passed_i,      // Target passed with nonzero end speed
    input wire [W-1:0] slip_err_i,   // Slippage error, signed
    input wire closed_loop_i,        // Closed-loop operation
    input wire qs_active_i,          // Power state machine quick stop active
    output reg [31:0] rdata_o,       // Read data, one cycle after strobe
    output reg [W-1:0] demand_o,     // Ramp generator demand output
    output reg [15:0] status_o,      // Statusword view
    output reg jerk_en_o,            // Jerk-limited ramps in use
    output reg [W-1:0] pos_dec_o     // Deceleration for positioning moves
);

    // Pin synchronisers (two flops each)
    reg [W-1:0] spd_s1_reg, spd_s2_reg;
    reg [31:0] pos_s1_reg, pos_s2_reg;
    reg [W-1:0] slp_s1_reg, slp_s2_reg;
    reg [3:0] bits_s1_reg, bits_s2_reg;
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            spd_s1_reg <= {W{1'b0}};
            spd_s2_reg <= {W{1'b0}};
            pos_s1_reg <= 32'h0;
            pos_s2_reg <= 32'h0;
            slp_s1_reg <= {W{1'b0}};
            slp_s2_reg <= {W{1'b0}};
            bits_s1_reg <= 4'h0;
            bits_s2_reg <= 4'h0;
        end else begin
            spd_s1_reg <= speed_act_i;
            spd_s2_reg <= spd_s1_reg;
            pos_s1_reg <= pos_act_i;
            pos_s2_reg <= pos_s1_reg;
            slp_s1_reg <= slip_err_i;
            slp_s2_reg <= slp_s1_reg;
            bits_s1_reg <= {target_passed_i, closed_loop_i, qs_active_i, 1'b0};
            bits_s2_reg <= bits_s1_reg;
        end
    end
    wire passed = bits_s2_reg[3];
    wire closed = bits_s2_reg[2];
    wire qs_act = bits_s2_reg[1];

    // Software registers
    reg [7:0] mode_reg, prof_reg;
    reg [15:0] ctrl_reg, pol_reg;
    reg [W-1:0] tgt_vl_reg, tgt_pv_reg, vmin_reg, vmax_reg;
    reg [W-1:0] acc_dv_reg, acc_dt_reg, dec_dv_reg, dec_dt_reg, qs_dv_reg, qs_dt_reg;
    reg [W-1:0] maxp_reg, maxm_reg, dmul_reg, ddiv_reg;
    reg [W-1:0] win_reg, thr_reg, slipmax_reg, pv_acc_reg, pv_dec_reg, qsdec_reg;
    reg [15:0] wint_reg, thrt_reg, slipt_reg;
    reg [W-1:0] jerk_reg [0:3];
    integer j;
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_reg <= 8'h00;
            prof_reg <= `PROF_TRAP;
            ctrl_reg <= 16'h0100;
            pol_reg <= 16'h0000;
            tgt_vl_reg <= {W{1'b0}};
            tgt_pv_reg <= {W{1'b0}};
            vmin_reg <= {W{1'b0}};
            vmax_reg <= {1'b0, {(W-1){1'b1}}};
            acc_dv_reg <= {W{1'b0}};
            acc_dt_reg <= {{(W-1){1'b0}}, 1'b1};
            dec_dv_reg <= {W{1'b0}};
            dec_dt_reg <= {{(W-1){1'b0}}, 1'b1};
            qs_dv_reg <= {W{1'b0}};
            qs_dt_reg <= {{(W-1){1'b0}}, 1'b1};
            maxp_reg <= {1'b0, {(W-1){1'b1}}};
            maxm_reg <= {1'b0, {(W-1){1'b1}}};
            dmul_reg <= {{(W-1){1'b0}}, 1'b1};
            ddiv_reg <= {{(W-1){1'b0}}, 1'b1};
            win_reg <= {W{1'b0}};
            thr_reg <= {W{1'b0}};
            slipmax_reg <= {1'b0, {(W-1){1'b1}}};
            pv_acc_reg <= {W{1'b0}};
            pv_dec_reg <= {W{1'b0}};
            qsdec_reg <= {W{1'b0}};
            wint_reg <= 16'h0000;
            thrt_reg <= 16'h0000;
            slipt_reg <= 16'h0000;
            for (j = 0; j < 4; j = j + 1) begin
                jerk_reg[j] <= {W{1'b0}};
            end
        end else if (wr_i) begin
            case (addr_i)
                `REG_MODE: mode_reg <= wdata_i[7:0];
                `REG_CTRL: ctrl_reg <= wdata_i[15:0];
                `REG_TARGET_VL: tgt_vl_reg <= wdata_i[W-1:0];
                `REG_TARGET_PV: tgt_pv_reg <= wdata_i[W-1:0];
                `REG_VMIN: vmin_reg <= wdata_i[W-1:0];
                `REG_VMAX: vmax_reg <= wdata_i[W-1:0];
                `REG_ACC_DV: acc_dv_reg <= wdata_i[W-1:0];
                `REG_ACC_DT: acc_dt_reg <= wdata_i[W-1:0];
                `REG_DEC_DV: dec_dv_reg <= wdata_i[W-1:0];
                `REG_DEC_DT: dec_dt_reg <= wdata_i[W-1:0];
                `REG_QS_DV: qs_dv_reg <= wdata_i[W-1:0];
                `REG_QS_DT: qs_dt_reg <= wdata_i[W-1:0];
                `REG_MAX_PROF_V: maxp_reg <= wdata_i[W-1:0];
                `REG_MAX_MOT_V: maxm_reg <= wdata_i[W-1:0];
                `REG_PROF_TYPE: prof_reg <= wdata_i[7:0];
                `REG_POLARITY: pol_reg <= wdata_i[15:0];
                `REG_DIM_MUL: dmul_reg <= wdata_i[W-1:0];
                `REG_DIM_DIV: ddiv_reg <= wdata_i[W-1:0];
                `REG_WIN: win_reg <= wdata_i[W-1:0];
                `REG_WIN_TIME: wint_reg <= wdata_i[15:0];
                `REG_THR: thr_reg <= wdata_i[W-1:0];
                `REG_THR_TIME: thrt_reg <= wdata_i[15:0];
                `REG_SLIP_MAX: slipmax_reg <= wdata_i[W-1:0];
                `REG_SLIP_TIME: slipt_reg <= wdata_i[15:0];
                `REG_PV_ACC: pv_acc_reg <= wdata_i[W-1:0];
                `REG_PV_DEC: pv_dec_reg <= wdata_i[W-1:0];
                `REG_QS_DEC_POS: qsdec_reg <= wdata_i[W-1:0];
                default: begin
                    if (addr_i >= `REG_JERK0 && addr_i < `REG_JERK0 + 6'h04) begin
                        jerk_reg[addr_i[1:0] - 2'h1] <= wdata_i[W-1:0];
                    end
                end
            endcase
        end
    end

    // Tick divider: one-cycle enable each control period
    reg [31:0] tick_cnt_reg;
    reg tick_reg;
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_cnt_reg <= 32'h0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TICK_CYCLES - 1) begin
            tick_cnt_reg <= 32'h0;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
            tick_reg <= 1'b0;
        end
    end

    // Mode decode, polarity, clamps and limits
    wire is_vl = (mode_reg == `MODE_VL);
    wire is_pv = (mode_reg == `MODE_PV);
    wire halt = ctrl_reg[`CTRL_HALT];
    wire signed [W-1:0] tgt_pol = pol_reg[`POL_VEL_BIT] ? -$signed(tgt_pv_reg)
                                : $signed(tgt_pv_reg);
    wire signed [W-1:0] tgt_raw = is_vl ? $signed(tgt_vl_reg) : tgt_pol;
    wire [W-1:0] tgt_mag = tgt_raw[W-1] ? -tgt_raw : tgt_raw;
    // Minimum and maximum applied to the magnitude, sign kept
    wire [W-1:0] vl_mag = (tgt_mag < vmin_reg) ? vmin_reg
                        : (tgt_mag > vmax_reg) ? vmax_reg : tgt_mag;
    wire vl_clip = is_vl && (tgt_mag < vmin_reg || tgt_mag > vmax_reg);
    wire [W-1:0] vlim = (maxp_reg < maxm_reg) ? maxp_reg : maxm_reg;
    wire [W-1:0] mag1 = is_vl ? vl_mag : tgt_mag;
    wire spd_clip = mag1 > vlim;
    wire [W-1:0] mag2 = spd_clip ? vlim : mag1;
    wire signed [W-1:0] tgt_eff = tgt_raw[W-1] ? -$signed(mag2) : $signed(mag2);
    wire signed [W-1:0] goal = (halt || qs_act || !(is_vl || is_pv)) ? {W{1'b0}}
                             : tgt_eff;

    // Step per tick: basic velocity and quick-stop speed change over seconds, scaled to tick rate; profile velocity steps as written
    wire [W-1:0] acc_st = is_vl ? acc_dv_reg / (acc_dt_reg * 1000) : pv_acc_reg;
    wire [W-1:0] dec_st = is_vl ? dec_dv_reg / (dec_dt_reg * 1000) : pv_dec_reg;
    wire [W-1:0] qs_st = qs_dv_reg / (qs_dt_reg * 1000);
    wire signed [W-1:0] dem = demand_o;
    wire signed [W-1:0] diff = goal - dem;
    wire [W-1:0] dmag = diff[W-1] ? -diff : diff;
    wire speeding_up = (goal[W-1] == dem[W-1] || dem == 0) &&
                       ((goal[W-1] ? -goal : goal) > (dem[W-1] ? -dem : dem));
    wire [W-1:0] step = qs_act ? qs_st : (speeding_up ? acc_st : dec_st);
    wire acc_clip = dmag > step;
    // Jerk ramps only in profile velocity mode with type 3
    wire jerk_sel = is_pv && (prof_reg == `PROF_JERK);

    // Ramp generator, advanced on the tick
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            demand_o <= {W{1'b0}};
        end else if (tick_reg) begin
            if (!acc_clip) begin
                demand_o <= goal;
            end else if (diff[W-1]) begin
                demand_o <= dem - $signed(step);
            end else begin
                demand_o <= dem + $signed(step);
            end
        end
    end

    // Positioning deceleration and jerk selection outputs
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pos_dec_o <= {W{1'b0}};
            jerk_en_o <= 1'b0;
        end else begin
            pos_dec_o <= qs_act ? qsdec_reg : pv_dec_reg;
            jerk_en_o <= jerk_sel;
        end
    end

    // Position sample each tick and offset base after target passed
    reg [31:0] pos_smp_reg, pos_base_reg;
    reg passed_d_reg;
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pos_smp_reg <= 32'h0;
            pos_base_reg <= 32'h0;
            passed_d_reg <= 1'b0;
        end else if (tick_reg) begin
            pos_smp_reg <= pos_s2_reg;
            passed_d_reg <= passed;
            if (passed && !passed_d_reg) begin
                pos_base_reg <= pos_s2_reg;
            end
        end
    end

    // Window, threshold and slip timers on the tick, magnitudes only
    wire signed [W-1:0] act = spd_s2_reg;
    wire [W-1:0] act_mag = act[W-1] ? -act : act;
    wire signed [W-1:0] err = act - tgt_eff;
    wire [W-1:0] err_mag = err[W-1] ? -err : err;
    wire [W-1:0] slip_mag = slp_s2_reg[W-1] ? -slp_s2_reg : slp_s2_reg;
    reg [15:0] win_cnt_reg, thr_cnt_reg, slip_cnt_reg;
    reg in_win_reg, above_reg, slip_reg;
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            win_cnt_reg <= 16'h0;
            thr_cnt_reg <= 16'h0;
            slip_cnt_reg <= 16'h0;
            in_win_reg <= 1'b0;
            above_reg <= 1'b0;
            slip_reg <= 1'b0;
        end else if (tick_reg) begin
            if (err_mag <= win_reg) begin
                if (win_cnt_reg < wint_reg) win_cnt_reg <= win_cnt_reg + 16'h1;
                else in_win_reg <= 1'b1;
            end else begin
                win_cnt_reg <= 16'h0;
                in_win_reg <= 1'b0;
            end
            if (act_mag > thr_reg) begin
                if (thr_cnt_reg < thrt_reg) thr_cnt_reg <= thr_cnt_reg + 16'h1;
                else above_reg <= 1'b1;
            end else begin
                thr_cnt_reg <= 16'h0;
                above_reg <= 1'b0;
            end
            if (closed && slip_mag > slipmax_reg) begin
                if (slip_cnt_reg <= slipt_reg) slip_cnt_reg <= slip_cnt_reg + 16'h1;
                else slip_reg <= 1'b1;
            end else begin
                slip_cnt_reg <= 16'h0;
                slip_reg <= 1'b0;
            end
        end
    end

    // Statusword assembly
    wire reached = halt ? (act_mag == 0 && demand_o == 0) : in_win_reg;
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_o <= 16'h0000;
        end else begin
            status_o <= 16'h0000;
            status_o[`CTRL_HALT] <= halt;
            status_o[`STS_REACHED] <= is_pv & reached;
            status_o[`STS_LIMIT] <= is_vl & (vl_clip | spd_clip | acc_clip);
            status_o[`STS_ZERO] <= is_pv & ~above_reg;
            status_o[`STS_SLIP] <= slip_reg;
            status_o[`STS_JERK_ON] <= jerk_sel;
        end
    end

    // Speed in rpm via dimension factor
    wire [2*W-1:0] rpm_prod = act * dmul_reg;
    wire [W-1:0] rpm = rpm_prod[W-1:0] / ddiv_reg;

    // Read port, data one cycle after the strobe
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            case (addr_i)
                `REG_MODE: rdata_o <= {24'h0, mode_reg};
                `REG_CTRL: rdata_o <= {16'h0, ctrl_reg};
                `REG_STATUS: rdata_o <= {16'h0, status_o};
                `REG_TARGET_VL: rdata_o <= tgt_vl_reg;
                `REG_TARGET_PV: rdata_o <= tgt_pv_reg;
                `REG_PROF_TYPE: rdata_o <= {24'h0, prof_reg};
                `REG_POLARITY: rdata_o <= {16'h0, pol_reg};
                `REG_DEMAND: rdata_o <= demand_o;
                `REG_ACTUAL: rdata_o <= spd_s2_reg;
                `REG_ACTUAL_RPM: rdata_o <= rpm;
                `REG_POS_SAMPLE: rdata_o <= pos_smp_reg;
                `REG_POS_BASE: rdata_o <= pos_base_reg;
                `REG_JERK0: rdata_o <= jerk_reg[0];
                default: rdata_o <= 32'h0;
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end

endmodule

// *** vel_ramp_chk.sv ***
// Concurrent checks on the ramp controller ports.
// Assumes it is bound to the controller and sees only its ports.
`timescale 1ns/1ps
`include "vel_ramp_defines.vh"
module vel_ramp_chk #(
    parameter W = 32
) (
    input wire clk_sys_i,         // Clock
    input wire nrst_i,            // Reset, active low
    input wire [5:0] addr_i,      // Address
    input wire [31:0] wdata_i,    // Write data
    input wire wr_i,              // Write strobe
    input wire rd_i,              // Read strobe
    input wire closed_loop_i,     // Closed loop
    input wire qs_active_i,       // Quick stop active
    input wire [31:0] rdata_o,    // Read data
    input wire [W-1:0] demand_o,  // Demand
    input wire [15:0] status_o,   // Status
    input wire jerk_en_o,         // Jerk on
    input wire [W-1:0] pos_dec_o  // Positioning decel
);
    reg [7:0] mode_q, prof_q;
    reg [31:0] qsd_q;

    // Shadow copies of the writes that steer the outputs
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_q <= 8'h00;
            prof_q <= 8'h00;
            qsd_q <= 32'h0;
        end else if (wr_i) begin
            if (addr_i == `REG_MODE) mode_q <= wdata_i[7:0];
            if (addr_i == `REG_PROF_TYPE) prof_q <= wdata_i[7:0];
            if (addr_i == `REG_QS_DEC_POS) qsd_q <= wdata_i;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    sequence s_bad_rd;
        rd_i && addr_i == 6'h3F;
    endsequence
    sequence s_qs_held;
        (qs_active_i && !wr_i) [*5];
    endsequence
    property p_rd_zero;
        s_bad_rd |=> rdata_o == 32'h0;
    endproperty
    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == 32'h0;
    endproperty
    property p_reset_trap;
        $rose(nrst_i) |-> !jerk_en_o [*2];
    endproperty
    property p_jerk_cause;
        jerk_en_o |-> $past(prof_q) == `PROF_JERK && $past(mode_q) == `MODE_PV;
    endproperty
    property p_trap_nojerk;
        (prof_q == `PROF_TRAP) [*3] |-> !jerk_en_o;
    endproperty
    property p_vl_nojerk;
        (mode_q == `MODE_VL) [*3] |-> !jerk_en_o;
    endproperty
    property p_qs_dec;
        s_qs_held |-> pos_dec_o == qsd_q;
    endproperty
    property p_limit_vl;
        status_o[`STS_LIMIT] |-> $past(mode_q) == `MODE_VL || $past(mode_q, 2) == `MODE_VL;
    endproperty
    property p_halt_stop;
        status_o[`STS_REACHED] && status_o[`CTRL_HALT] |-> $past(demand_o) == 0;
    endproperty
    property p_slip;
        $rose(status_o[`STS_SLIP]) |-> closed_loop_i;
    endproperty

    a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    a_reset_trap: assert property (p_reset_trap) else $error("jerk on after reset");
    a_jerk_cause: assert property (p_jerk_cause) else $error("jerk on without cause");
    a_trap_nojerk: assert property (p_trap_nojerk) else $error("jerk on in trapezoid");
    a_vl_nojerk: assert property (p_vl_nojerk) else $error("jerk on in velocity");
    a_qs_dec: assert property (p_qs_dec) else $error("quick-stop decel not used");
    a_limit_vl: assert property (p_limit_vl) else $error("limit flag outside mode");
    a_halt_stop: assert property (p_halt_stop) else $error("stopped flag with demand");
    a_slip: assert property (p_slip) else $error("slip flag in open loop");
endmodule

// *** fieldbus_master.sv ***
// Register master standing in for the fieldbus side.
// Assumes the controller clock and a read answer one cycle after the strobe.
`timescale 1ns/1ps
`include "vel_ramp_defines.vh"
module fieldbus_master (
    input wire clk_sys_i,      // Clock
    input wire [31:0] rdata_i, // Read data
    output reg [5:0] addr_o = 6'h00,   // Address
    output reg [31:0] wdata_o = 32'h0, // Write data
    output reg wr_o = 1'b0,            // Write strobe
    output reg rd_o = 1'b0             // Read strobe
);
    // One-cycle write
    task wr(input [5:0] a, input [31:0] d);
        begin
            @(posedge clk_sys_i);
            addr_o <= a;
            wdata_o <= d;
            wr_o <= 1'b1;
            @(posedge clk_sys_i);
            wr_o <= 1'b0;
        end
    endtask
    // One-cycle read, data taken in the following cycle
    task rd(input [5:0] a, output [31:0] d);
        begin
            @(posedge clk_sys_i);
            addr_o <= a;
            rd_o <= 1'b1;
            @(posedge clk_sys_i);
            rd_o <= 1'b0;
            @(posedge clk_sys_i);
            d = rdata_i;
        end
    endtask
    // Mode select, codes 2 and 3 only
    task set_mode(input [7:0] m);
        wr(`REG_MODE, {24'h0, m});
    endtask
    // Speed change is always written positive, time follows it
    task set_ramp(input [5:0] a, input [31:0] dv, input [31:0] dt);
        begin
            wr(a, dv & 32'h7FFFFFFF);
            wr(a + 6'h01, dt);
        end
    endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the ramp controller.
// Assumes a short control tick so that ramps finish in a few hundred cycles.
`timescale 1ns/1ps
`include "vel_ramp_defines.vh"
module testbench;
    localparam TCK = 8;
    reg clk_sys_i = 1'b0;
    reg nrst_i = 1'b0;
    reg [31:0] speed_act_i = 32'h0;
    reg [31:0] pos_act_i = 32'h0;
    reg target_passed_i = 1'b0;
    reg [31:0] slip_err_i = 32'h0;
    reg closed_loop_i = 1'b0;
    reg qs_active_i = 1'b0;
    wire [5:0] addr;
    wire [31:0] wdata, rdata_o, demand_o, pos_dec_o;
    wire wr, rd, jerk_en_o;
    wire [15:0] status_o;
    integer n_mismatch = 0;
    integer tests_run = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;

    fieldbus_master m (.clk_sys_i(clk_sys_i), .rdata_i(rdata_o), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    vel_ramp_ctrl #(.TICK_CYCLES(TCK), .W(32)) DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .speed_act_i(speed_act_i),
        .pos_act_i(pos_act_i), .target_passed_i(target_passed_i), .slip_err_i(slip_err_i),
        .closed_loop_i(closed_loop_i), .qs_active_i(qs_active_i), .rdata_o(rdata_o),
        .demand_o(demand_o), .status_o(status_o), .jerk_en_o(jerk_en_o), .pos_dec_o(pos_dec_o));

    // Verdict and end of run
    task report_and_stop;
        begin
            if (n_mismatch == 0 && tests_run > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // Compare seen against expected
    task chk(input string nm, input [31:0] seen, input [31:0] e);
        begin
            tests_run = tests_run + 1;
            if (seen !== e) begin
                $display("unexpected %s expected %h seen %h", nm, e, seen);
                n_mismatch = n_mismatch + 1;
            end
        end
    endtask
    task rchk(input string nm, input [5:0] a, input [31:0] e);
        reg [31:0] d;
        begin
            m.rd(a, d);
            chk(nm, d, e);
        end
    endtask
    // Bounded wait for the demand to settle, gives the cycles spent
    task wait_dem(input [31:0] e, output integer n);
        begin
            n = 0;
            while (demand_o !== e && n < 3000) begin
                @(posedge clk_sys_i);
                n = n + 1;
            end
            chk("demand", demand_o, e);
            if (demand_o !== e) report_and_stop;
        end
    endtask
    task ticks(input integer k);
        repeat (k * TCK) @(posedge clk_sys_i);
    endtask

    // Hang guard
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        n_mismatch = n_mismatch + 1;
        report_and_stop;
    end

    // Main sequence
    initial begin
        integer n;
        repeat (10) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rchk("prof_type", `REG_PROF_TYPE, 32'h0);
        rchk("ctrl", `REG_CTRL, 32'h100);
        rchk("unmapped", 6'h3F, 32'h0);
        // Basic velocity: clamp, ramps, quick stop
        m.wr(`REG_VMIN, 32'd10);
        m.wr(`REG_VMAX, 32'd100);
        m.set_ramp(`REG_ACC_DV, 32'd5000, 32'd1);
        m.set_ramp(`REG_DEC_DV, 32'd10000, 32'd1);
        m.set_ramp(`REG_QS_DV, 32'd20000, 32'd1);
        m.wr(`REG_TARGET_VL, 32'd500);
        m.wr(`REG_PROF_TYPE, 32'h3);
        m.set_mode(`MODE_VL);
        m.wr(`REG_CTRL, 32'h0);
        wait_dem(32'd100, n);
        chk("acc_time", {31'h0, n >= 19 * TCK}, 32'h1);
        chk("limit_on", {31'h0, status_o[`STS_LIMIT]}, 32'h1);
        chk("jerk_vl", {31'h0, jerk_en_o}, 32'h0);
        rchk("demand_rd", `REG_DEMAND, 32'd100);
        qs_active_i <= 1'b1;
        wait_dem(32'h0, n);
        chk("qs_time", {31'h0, n <= 6 * TCK + 8}, 32'h1);
        qs_active_i <= 1'b0;
        m.wr(`REG_TARGET_VL, 32'd3);
        wait_dem(32'd10, n);
        m.wr(`REG_TARGET_VL, 32'd50);
        wait_dem(32'd50, n);
        ticks(2);
        chk("limit_off", {31'h0, status_o[`STS_LIMIT]}, 32'h0);
        m.wr(`REG_CTRL, 32'h100);
        wait_dem(32'h0, n);
        chk("dec_time", {31'h0, n <= 6 * TCK + 4}, 32'h1);
        // Profile velocity: maxima, polarity, jerk selection
        m.set_mode(`MODE_PV);
        m.wr(`REG_TARGET_PV, 32'd200);
        m.wr(`REG_MAX_PROF_V, 32'd60);
        m.wr(`REG_MAX_MOT_V, 32'd80);
        m.wr(`REG_PV_ACC, 32'd20);
        m.wr(`REG_PV_DEC, 32'd30);
        m.wr(`REG_CTRL, 32'h0);
        wait_dem(32'd60, n);
        chk("jerk_pv", {31'h0, jerk_en_o}, 32'h1);
        m.wr(`REG_MAX_MOT_V, 32'd50);
        wait_dem(32'd50, n);
        m.wr(`REG_POLARITY, 32'h40);
        wait_dem(32'hFFFFFFCE, n);
        m.wr(`REG_POLARITY, 32'h0);
        m.wr(`REG_PROF_TYPE, 32'h0);
        wait_dem(32'd50, n);
        chk("jerk_trap", {31'h0, jerk_en_o}, 32'h0);
        // Reached, braking, stopped and zero-speed flags
        m.wr(`REG_WIN, 32'd5);
        m.wr(`REG_WIN_TIME, 32'd2);
        m.wr(`REG_THR, 32'd5);
        m.wr(`REG_THR_TIME, 32'd2);
        speed_act_i <= 32'd50;
        ticks(5);
        chk("reached", {30'h0, status_o[`STS_REACHED], status_o[`CTRL_HALT]}, 32'h2);
        chk("moving", {31'h0, status_o[`STS_ZERO]}, 32'h0);
        speed_act_i <= 32'hFFFFFFCE;
        ticks(5);
        chk("moving_rev", {31'h0, status_o[`STS_ZERO]}, 32'h0);
        m.wr(`REG_CTRL, 32'h100);
        repeat (2) @(posedge clk_sys_i);
        chk("braking", {30'h0, status_o[`STS_REACHED], status_o[`CTRL_HALT]}, 32'h1);
        wait_dem(32'h0, n);
        speed_act_i <= 32'h0;
        ticks(5);
        chk("stopped", {30'h0, status_o[`STS_REACHED], status_o[`CTRL_HALT]}, 32'h3);
        chk("zero", {31'h0, status_o[`STS_ZERO]}, 32'h1);
        // Speed readback and unit conversion
        speed_act_i <= 32'd20;
        m.wr(`REG_DIM_MUL, 32'd3);
        m.wr(`REG_DIM_DIV, 32'd2);
        ticks(1);
        rchk("rpm", `REG_ACTUAL_RPM, 32'd30);
        rchk("actual", `REG_ACTUAL, 32'd20);
        // Slippage in closed loop
        m.wr(`REG_SLIP_MAX, 32'd5);
        m.wr(`REG_SLIP_TIME, 32'd2);
        closed_loop_i <= 1'b1;
        slip_err_i <= 32'd10;
        ticks(5);
        chk("slip", {31'h0, status_o[`STS_SLIP]}, 32'h1);
        closed_loop_i <= 1'b0;
        slip_err_i <= 32'h0;
        // Positioning deceleration choice
        m.wr(`REG_QS_DEC_POS, 32'd77);
        repeat (6) @(posedge clk_sys_i);
        chk("pos_dec", pos_dec_o, 32'd30);
        qs_active_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        chk("pos_dec_qs", pos_dec_o, 32'd77);
        qs_active_i <= 1'b0;
        // Position sampling and offset base
        pos_act_i <= 32'd1234;
        ticks(2);
        rchk("pos_sample", `REG_POS_SAMPLE, 32'd1234);
        target_passed_i <= 1'b1;
        ticks(2);
        pos_act_i <= 32'd999;
        ticks(2);
        rchk("pos_base", `REG_POS_BASE, 32'd1234);
        rchk("pos_sample2", `REG_POS_SAMPLE, 32'd999);
        report_and_stop;
    end
endmodule

bind vel_ramp_ctrl vel_ramp_chk #(.W(W)) chk_u (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .closed_loop_i(closed_loop_i), .qs_active_i(qs_active_i),
    .rdata_o(rdata_o),
    .demand_o(demand_o), .status_o(status_o), .jerk_en_o(jerk_en_o), .pos_dec_o(pos_dec_o));
